// ==== design/dhps_pkg.sv ====
// Shared constants and pin bundle for the dual host port select block
package dhps_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_NS = 40;
  // Least time, rounded up to whole cycles
  localparam int RST_HOLD_INT = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] RST_HOLD_CYC = 3'(RST_HOLD_INT);
  localparam int BYTE_W = 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] SPI_LAST_BIT = 4'h7;
  localparam int PIN_W = 6;
  // Arbitrary default for the upper slave address bits
  localparam logic [4:0] I2C_ADDR_BASE_DEF = 5'h1A;
  localparam logic MODE_I2C = 1'b1;
  localparam logic MODE_SPI = 1'b0;

  typedef struct packed {
    logic scl;
    logic sda;
    logic cs_n;
    logic si;
    logic sel;
    logic rx;
  } dhps_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WRITE,
    ST_ACK_WR,
    ST_READ,
    ST_ACK_RD,
    ST_SPI_XFER
  } dhps_state_t;
endpackage : dhps_pkg

// ==== design/dhps_sync.sv ====
// Two flip-flop synchroniser for the pin inputs
module dhps_sync #(
  parameter int WIDTH = 6
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = clk_en_in ? async_in : meta_reg;
    sync_next = clk_en_in ? meta_reg : sync_reg;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : dhps_sync

// ==== design/dhps_top.sv ====
// Host port front end: I2C or SPI slave on shared pins, reset, IRQ and TX pins
module dhps_top
  import dhps_pkg::*;
#(
  parameter logic [4:0] I2C_ADDR_BASE = dhps_pkg::I2C_ADDR_BASE_DEF
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic port_sel_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_strap_zero_in,
  input wire logic addr_strap_one_in,
  input wire logic rxd_in,
  input wire logic tx_serial_in,
  input wire logic tx_active_in,
  input wire logic irq_pending_in,
  input wire logic [dhps_pkg::BYTE_W-1:0] rd_data_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic so_out,
  output logic so_oe_out,
  output logic irq_n_out,
  output logic irq_oe_out,
  output logic txd_out,
  output logic rx_data_out,
  output logic [dhps_pkg::BYTE_W-1:0] wr_data_out,
  output logic wr_valid_out,
  output logic rd_req_out,
  output logic busy_out,
  output logic i2c_mode_out
);
  import dhps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  dhps_pins_t pins_raw;
  dhps_pins_t pins;
  logic [PIN_W-1:0] pins_sync;

  assign pins_raw = '{scl: scl_in, sda: sda_in, cs_n: addr_strap_zero_in, si: addr_strap_one_in,
                      sel: port_sel_in, rx: rxd_in};

  dhps_sync #(.WIDTH(PIN_W)) u_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .clk_en_in(clk_en_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );
  assign pins = dhps_pins_t'(pins_sync);

  ////////////////////////////////////////////////////////////////////////////
  // Reset stretch and pin-side outputs
  logic [2:0] rst_cnt_reg, rst_cnt_next;
  logic ready;
  logic txd_reg, txd_next;
  logic rx_reg, rx_next;
  logic irq_oe_reg, irq_oe_next;
  logic drive_low_reg;

  // Async reset covers any low pulse; the stretch keeps the port quiet a little longer
  assign ready = (rst_cnt_reg == RST_HOLD_CYC);

  always_comb begin
    rst_cnt_next = ready ? rst_cnt_reg : rst_cnt_reg + 3'h1;
    txd_next = ready & tx_active_in & tx_serial_in;
    rx_next = ready & pins.rx;
    irq_oe_next = ready & irq_pending_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_cnt_reg <= 3'h0;
      txd_reg <= 1'b0;
      rx_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (clk_en_in) begin
      rst_cnt_reg <= rst_cnt_next;
      txd_reg <= txd_next;
      rx_reg <= rx_next;
      irq_oe_reg <= irq_oe_next;
      drive_low_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port engine
  dhps_state_t state_reg, state_next;
  logic mode_reg, mode_next;
  logic scl_prev_reg, scl_prev_next;
  logic sda_prev_reg, sda_prev_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic rw_reg, rw_next;
  logic sda_oe_reg, sda_oe_next;
  logic so_reg, so_next;
  logic so_oe_reg, so_oe_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic wr_valid_reg, wr_valid_next;
  logic rd_req_reg, rd_req_next;
  logic busy_reg, busy_next;
  logic rise, fall, start_cond, stop_cond;
  logic [6:0] own_addr;

  assign rise = pins.scl & ~scl_prev_reg;
  assign fall = ~pins.scl & scl_prev_reg;
  assign start_cond = pins.scl & scl_prev_reg & sda_prev_reg & ~pins.sda;
  assign stop_cond = pins.scl & scl_prev_reg & ~sda_prev_reg & pins.sda;
  assign own_addr = {I2C_ADDR_BASE, pins.si, pins.cs_n};

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    scl_prev_next = pins.scl;
    sda_prev_next = pins.sda;
    cnt_next = cnt_reg;
    rx_sh_next = rx_sh_reg;
    tx_sh_next = tx_sh_reg;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    so_next = so_reg;
    so_oe_next = so_oe_reg;
    wr_data_next = wr_data_reg;
    wr_valid_next = 1'b0;
    rd_req_next = 1'b0;
    if (!ready) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      so_oe_next = 1'b0;
    end else if (mode_reg == MODE_I2C) begin
      so_oe_next = 1'b0;
      if (start_cond) begin
        state_next = ST_ADDR;
        cnt_next = 4'h0;
        sda_oe_next = 1'b0;
      end else if (stop_cond) begin
        state_next = ST_IDLE;
        sda_oe_next = 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (rise) begin
              rx_sh_next = {rx_sh_reg[6:0], pins.sda};
              cnt_next = cnt_reg + 4'h1;
            end else if (fall && cnt_reg == BYTE_BITS) begin
              if (rx_sh_reg[7:1] == own_addr) begin
                sda_oe_next = 1'b1;
                rw_next = rx_sh_reg[0];
                state_next = ST_ACK_ADDR;
              end else begin
                state_next = ST_IDLE;
              end
            end
          end
          ST_ACK_ADDR, ST_ACK_RD: begin
            if (state_reg == ST_ACK_RD && rise) begin
              rw_next = ~pins.sda;
            end else if (fall) begin
              cnt_next = 4'h0;
              if (rw_reg) begin
                tx_sh_next = rd_data_in;
                rd_req_next = 1'b1;
                sda_oe_next = ~rd_data_in[7];
                state_next = ST_READ;
              end else begin
                sda_oe_next = 1'b0;
                state_next = (state_reg == ST_ACK_ADDR) ? ST_WRITE : ST_IDLE;
              end
            end
          end
          ST_WRITE: begin
            if (rise) begin
              rx_sh_next = {rx_sh_reg[6:0], pins.sda};
              cnt_next = cnt_reg + 4'h1;
            end else if (fall && cnt_reg == BYTE_BITS) begin
              wr_data_next = rx_sh_reg;
              wr_valid_next = 1'b1;
              sda_oe_next = 1'b1;
              state_next = ST_ACK_WR;
            end
          end
          ST_ACK_WR: begin
            if (fall) begin
              sda_oe_next = 1'b0;
              cnt_next = 4'h0;
              state_next = ST_WRITE;
            end
          end
          ST_READ: begin
            if (rise) begin
              cnt_next = cnt_reg + 4'h1;
            end else if (fall) begin
              if (cnt_reg == BYTE_BITS) begin
                sda_oe_next = 1'b0;
                state_next = ST_ACK_RD;
              end else begin
                tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                sda_oe_next = ~tx_sh_reg[6];
              end
            end
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end
    end else begin
      sda_oe_next = 1'b0;
      if (pins.cs_n) begin
        state_next = ST_IDLE;
        so_oe_next = 1'b0;
        cnt_next = 4'h0;
      end else if (state_reg != ST_SPI_XFER) begin
        state_next = ST_SPI_XFER;
        tx_sh_next = rd_data_in;
        rd_req_next = 1'b1;
        so_next = rd_data_in[7];
        so_oe_next = 1'b1;
        cnt_next = 4'h0;
        rw_next = 1'b0;
      end else begin
        if (rise) begin
          rx_sh_next = {rx_sh_reg[6:0], pins.si};
          if (cnt_reg == SPI_LAST_BIT) begin
            wr_data_next = {rx_sh_reg[6:0], pins.si};
            wr_valid_next = 1'b1;
            cnt_next = 4'h0;
            rw_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end else if (fall) begin
          if (rw_reg) begin
            tx_sh_next = rd_data_in;
            rd_req_next = 1'b1;
            so_next = rd_data_in[7];
            rw_next = 1'b0;
          end else begin
            tx_sh_next = {tx_sh_reg[6:0], 1'b0};
            so_next = tx_sh_reg[6];
          end
        end
      end
    end
    // Strap is read only while idle and staying idle, so the mode never changes once a transfer has started
    if (state_reg == ST_IDLE && state_next == ST_IDLE) begin
      mode_next = pins.sel;
    end
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      mode_reg <= MODE_SPI;
      scl_prev_reg <= 1'b0;
      sda_prev_reg <= 1'b0;
      cnt_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_valid_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
      cnt_reg <= cnt_next;
      rx_sh_reg <= rx_sh_next;
      tx_sh_reg <= tx_sh_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
      so_reg <= so_next;
      so_oe_reg <= so_oe_next;
      wr_data_reg <= wr_data_next;
      wr_valid_reg <= wr_valid_next;
      rd_req_reg <= rd_req_next;
      busy_reg <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Open-drain pins: level flop is held low, only the enable moves
  assign sda_out = drive_low_reg;
  assign sda_oe_out = sda_oe_reg;
  assign irq_n_out = drive_low_reg;
  assign irq_oe_out = irq_oe_reg;
  assign so_out = so_reg;
  assign so_oe_out = so_oe_reg;
  assign txd_out = txd_reg;
  assign rx_data_out = rx_reg;
  assign wr_data_out = wr_data_reg;
  assign wr_valid_out = wr_valid_reg;
  assign rd_req_out = rd_req_reg;
  assign busy_out = busy_reg;
  assign i2c_mode_out = mode_reg;
endmodule : dhps_top

// ==== tb/dhps_top_assertions.sv ====
// Checker for the host port front end pins
module dhps_top_assertions (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic addr_strap_zero_in,
  input wire logic tx_serial_in,
  input wire logic tx_active_in,
  input wire logic irq_pending_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic so_oe_out,
  input wire logic irq_n_out,
  input wire logic irq_oe_out,
  input wire logic txd_out,
  input wire logic wr_valid_out,
  input wire logic busy_out,
  input wire logic i2c_mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Six cycles covers sync delay plus one release cycle
  sequence s_cs_idle;
    (!i2c_mode_out && addr_strap_zero_in) [*6];
  endsequence
  // Select falling in SPI mode; sync delay puts the answer three edges later
  sequence s_cs_fall;
    !i2c_mode_out && $fell(addr_strap_zero_in);
  endsequence
  chk_txd_cause: assert property (txd_out |-> $past(tx_active_in && tx_serial_in))
    else $error("txd high without an active one bit");
  chk_txd_stretch: assert property ($rose(rstn_in) |-> !txd_out [*3])
    else $error("txd active during reset stretch");
  chk_irq_cause: assert property (irq_oe_out |-> $past(irq_pending_in))
    else $error("irq pulled without pending cause");
  chk_irq_drain: assert property (irq_n_out == 1'b0)
    else $error("irq data not low");
  chk_sda_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_sda_spi: assert property (!i2c_mode_out |-> !sda_oe_out)
    else $error("sda pulled in spi mode");
  chk_so_i2c: assert property (i2c_mode_out |-> !so_oe_out)
    else $error("so driven in i2c mode");
  chk_cs_quiet: assert property (s_cs_idle |-> !so_oe_out && !wr_valid_out)
    else $error("spi active with chip select high");
  chk_mode_hold: assert property (busy_out && $past(busy_out) |-> $stable(i2c_mode_out))
    else $error("mode changed mid transfer");
  chk_spi_answer: assert property (s_cs_fall |-> ##[1:4] so_oe_out)
    else $error("so not driven after chip select low");
endmodule : dhps_top_assertions

bind dhps_top dhps_top_assertions chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .addr_strap_zero_in(addr_strap_zero_in), .tx_serial_in(tx_serial_in), .tx_active_in(tx_active_in),
  .irq_pending_in(irq_pending_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .so_oe_out(so_oe_out),
  .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out), .txd_out(txd_out), .wr_valid_out(wr_valid_out),
  .busy_out(busy_out), .i2c_mode_out(i2c_mode_out));

// ==== tb/dhps_host_model.sv ====
// Host master model driving the shared serial pins
module dhps_host_model (
  input wire logic core_clk_in,
  input wire logic sda_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output logic scl_out,
  output logic sda_pull_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_out = 1'b0;
    sda_pull_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  task w(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : w
  // Clock idles low for spi, high for i2c
  task idle(input logic lvl);
    scl_out = lvl;
  endtask : idle
  task strap(input logic [1:0] s);
    {si_out, cs_n_out} = s;
  endtask : strap
  // Released so reads as unknown, so a missing drive fails
  task spi_xfer(input logic en, input logic [7:0] tx, output logic [7:0] rx);
    cs_n_out = !en;
    w(8);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      w(5);
      scl_out = 1'b1;
      rx[i] = so_oe_in ? so_in : 1'bx;
      w(3);
      scl_out = 1'b0;
    end
    w(5);
    cs_n_out = 1'b1;
    si_out = ~si_out;
  endtask : spi_xfer
  task i2c_start;
    sda_pull_out = 1'b1;
    w(5);
    scl_out = 1'b0;
  endtask : i2c_start
  task i2c_bit(input logic b, output logic s);
    sda_pull_out = !b;
    w(5);
    scl_out = 1'b1;
    w(2);
    s = sda_in;
    w(1);
    scl_out = 1'b0;
  endtask : i2c_bit
  task i2c_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], s);
    i2c_bit(1'b1, s);
    ack = !s;
  endtask : i2c_byte
  task i2c_stop;
    sda_pull_out = 1'b1;
    w(5);
    scl_out = 1'b1;
    w(5);
    sda_pull_out = 1'b0;
    w(5);
  endtask : i2c_stop
endmodule : dhps_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the host port front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dhps_pkg::*;
  localparam logic [4:0] BASE = 5'h15;
  logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, tx_s = 1'b1, tx_a = 1'b1, irq_p = 1'b1;
  logic clk_en = 1'b1, rxd = 1'b1;
  logic sda_o, irq_n_o, rd_r;
  logic [7:0] rd_data = 8'h3C, last_wr, rx;
  logic scl, sda_pull, cs_n, si, sda_oe, so, so_oe, irq_oe, txd, rxo, wr_v, busy, mode, ack;
  logic [7:0] wr_data;
  int n_errors = 0, cmp_count = 0, wr_cnt = 0, w0, rd_cnt = 0, r0;
  always #5 clk = ~clk;
  // Pull-up on the open-drain data line
  wire sda_w = !(sda_pull || sda_oe);
  dhps_host_model host (.core_clk_in(clk), .sda_in(sda_w), .so_in(so), .so_oe_in(so_oe), .scl_out(scl),
    .sda_pull_out(sda_pull), .cs_n_out(cs_n), .si_out(si));
  dhps_top #(.I2C_ADDR_BASE(BASE)) dut (.core_clk_in(clk), .rstn_in(rstn), .clk_en_in(clk_en),
    .port_sel_in(sel), .scl_in(scl), .sda_in(sda_w), .addr_strap_zero_in(cs_n), .addr_strap_one_in(si),
    .rxd_in(rxd), .tx_serial_in(tx_s), .tx_active_in(tx_a), .irq_pending_in(irq_p), .rd_data_in(rd_data),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .so_out(so), .so_oe_out(so_oe), .irq_n_out(irq_n_o),
    .irq_oe_out(irq_oe), .txd_out(txd), .rx_data_out(rxo), .wr_data_out(wr_data), .wr_valid_out(wr_v),
    .rd_req_out(rd_r), .busy_out(busy), .i2c_mode_out(mode));
  always @(posedge clk) if (wr_v === 1'b1) begin
    wr_cnt <= wr_cnt + 1;
    last_wr <= wr_data;
  end
  always @(posedge clk) if (rd_r === 1'b1) begin
    rd_cnt <= rd_cnt + 1;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rstn = 1'b0;
    host.w(5);
    chk("reset outs", 8'h00, {txd, irq_oe, rxo, sda_oe, so_oe, busy, sda_o, irq_n_o});
    rstn = 1'b1;
    host.w(2);
    chk("stretch", 8'h00, {6'h00, txd, rxo});
    host.w(8);
    chk("txd irq rx on", 8'h07, {5'h00, txd, irq_oe, rxo});
    tx_a = 1'b0;
    irq_p = 1'b0;
    rxd = 1'b0;
    host.w(3);
    chk("txd irq rx off", 8'h00, {5'h00, txd, irq_oe, rxo});
    // Enable low must freeze the synchronisers as well
    clk_en = 1'b0;
    rxd = 1'b1;
    host.w(4);
    chk("frozen rx", 8'h00, {7'h00, rxo});
    clk_en = 1'b1;
    host.w(4);
    chk("thawed rx", 8'h01, {7'h00, rxo});
    $display("test reset done");
  endtask : t_reset
  task t_spi;
    chk("spi mode", 8'h00, {7'h00, mode});
    w0 = wr_cnt;
    r0 = rd_cnt;
    host.spi_xfer(1'b1, 8'hA5, rx);
    chk("spi rx", 8'h3C, rx);
    chk("spi wr", 8'hA5, last_wr);
    chk("spi loads", 8'h02, 8'(rd_cnt - r0));
    host.w(6);
    chk("so released", 8'h00, {7'h00, so_oe});
    host.spi_xfer(1'b0, 8'h5A, rx);
    chk("cs high count", 8'(w0 + 1), 8'(wr_cnt));
    chk("cs high loads", 8'h02, 8'(rd_cnt - r0));
    $display("test spi done");
  endtask : t_spi
  task t_i2c(input logic [1:0] s);
    sel = 1'b1;
    host.idle(1'b1);
    host.strap(s);
    host.w(12);
    chk("i2c mode", 8'h01, {7'h00, mode});
    r0 = rd_cnt;
    host.i2c_start();
    host.i2c_byte({BASE, s, 1'b0}, ack);
    chk("addr ack", 8'h01, {7'h00, ack});
    sel = 1'b0;
    host.i2c_byte(8'hC3 ^ {6'h00, s}, ack);
    chk("data ack", 8'h01, {7'h00, ack});
    chk("mode held", 8'h01, {7'h00, mode});
    chk("od levels", 8'h00, {6'h00, sda_o, irq_n_o});
    chk("so quiet", 8'h00, {7'h00, so_oe});
    // Strap back before the stop, or the idle port would follow it to SPI
    sel = 1'b1;
    host.i2c_stop();
    chk("i2c wr", 8'hC3 ^ {6'h00, s}, last_wr);
    chk("wr loads", 8'h00, 8'(rd_cnt - r0));
    host.w(12);
    host.i2c_start();
    host.i2c_byte({BASE, ~s, 1'b0}, ack);
    chk("wrong addr", 8'h00, {7'h00, ack});
    host.i2c_stop();
    $display("test i2c done");
  endtask : t_i2c
  task t_i2c_rd(input logic [1:0] s);
    logic b;
    r0 = rd_cnt;
    rd_data = 8'h96;
    host.w(4);
    host.i2c_start();
    host.i2c_byte({BASE, s, 1'b1}, ack);
    chk("rd addr ack", 8'h01, {7'h00, ack});
    for (int i = 7; i >= 0; i--) begin
      host.i2c_bit(1'b1, b);
      rx[i] = b;
    end
    host.i2c_bit(1'b1, b);
    chk("i2c rd", 8'h96, rx);
    chk("rd released", 8'h01, {7'h00, b});
    chk("rd loads", 8'h01, 8'(rd_cnt - r0));
    host.i2c_stop();
    chk("rd idle", 8'h01, {6'h00, busy, mode});
    $display("test i2c read done");
  endtask : t_i2c_rd
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    t_reset();
    t_spi();
    t_i2c(2'b01);
    t_i2c(2'b10);
    t_i2c_rd(2'b10);
    report_and_stop();
  end
endmodule : tb_top
